// *** bench/decode_chk_sva.sv ***
// Assertions on the decoder's outputs
`timescale 1ns/100ps
module decode_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] source_a_data,
    input wire logic [63:0] source_b_data,
    input wire logic user_or_super,
    input wire logic sysctl_enabled,
    input wire logic [63:0] sysctl_rdata,
    input wire logic mem_bus_error,
    input wire logic gpr_we,
    input wire logic [4:0] gpr_waddr,
    input wire logic [63:0] gpr_wdata,
    input wire logic sysctl_we,
    input wire logic [63:0] sysctl_wdata,
    input wire logic store_req,
    input wire logic [63:0] store_addr,
    input wire logic [7:0] store_byte,
    input wire logic exc_valid,
    input wire logic [4:0] exc_code,
    input wire logic [63:0] upper_product_reg,
    input wire logic [63:0] bottom_product_reg
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    wire logic spec = instr_valid && instr[31:26] == isa_decode_pkg::OP_SPECIAL;
    wire logic cop = instr_valid && instr[31:26] == isa_decode_pkg::OP_COP0;
    wire logic deny = user_or_super && !sysctl_enabled;
    wire logic [5:0] fn = instr[5:0];
    wire logic [63:0] smul = $signed({{32{source_a_data[31]}}, source_a_data[31:0]})
        * $signed({{32{source_b_data[31]}}, source_b_data[31:0]});
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    or_result_a: assert property (
        spec && fn == isa_decode_pkg::FN_OR |=> gpr_we
        && gpr_wdata == $past(source_a_data | source_b_data))
        else $error("or result wrong");
    nor_result_a: assert property (
        spec && fn == isa_decode_pkg::FN_NOR |=> gpr_we
        && gpr_wdata == ~$past(source_a_data | source_b_data))
        else $error("nor result wrong");
    ori_result_a: assert property (
        instr_valid && instr[31:26] == isa_decode_pkg::OP_ORI |=> gpr_we
        && gpr_waddr == $past(instr[20:16])
        && gpr_wdata == $past(source_a_data | {48'h0, instr[15:0]}))
        else $error("immediate or wrong");
    store_addr_a: assert property (
        instr_valid && instr[31:26] == isa_decode_pkg::OP_SB |=> store_req
        && store_addr == $past(source_a_data + {{48{instr[15]}}, instr[15:0]})
        && store_byte == $past(source_b_data[7:0]))
        else $error("byte store wrong");
    sysctl_write_a: assert property (
        cop && instr[25:21] == isa_decode_pkg::CP_WRITE && !deny |-> ##2 sysctl_we
        && sysctl_wdata == $past(source_b_data, 2))
        else $error("control write wrong");
    sysctl_read_a: assert property (
        cop && instr[25:21] == isa_decode_pkg::CP_READ && !deny |=> gpr_we
        && gpr_wdata == $past(sysctl_rdata))
        else $error("control read wrong");
    cop_refuse_a: assert property (
        cop && deny |=> exc_valid && exc_code == isa_decode_pkg::ECODE_CPU && !gpr_we
        ##1 !sysctl_we)
        else $error("control refusal wrong");
    upper_read_a: assert property (
        spec && fn == isa_decode_pkg::FN_RD_UP |=> gpr_we
        && gpr_wdata == $past(upper_product_reg))
        else $error("upper read wrong");
    signed_product_a: assert property (
        spec && fn == isa_decode_pkg::FN_MUL_S |=> !exc_valid
        && bottom_product_reg == $past({{32{smul[31]}}, smul[31:0]})
        && upper_product_reg == $past({{32{smul[63]}}, smul[63:32]}))
        else $error("signed product wrong");
    bus_fault_a: assert property (
        store_req && mem_bus_error |=> exc_valid && exc_code == 5'h07)
        else $error("bus fault missed");
    macc_c: cover property (instr_valid && instr[31:26] == isa_decode_pkg::OP_MACC);
    fault_c: cover property (store_req && mem_bus_error);
    refuse_c: cover property (cop && deny);
endmodule : decode_chk

bind hilo_cop_logic_store_decode decode_chk decode_chk_i (.*);

// *** bench/hilo_cop_logic_store_decode_tb.sv ***
// Self-checking bench for the decoder
`timescale 1ns/100ps
module hilo_cop_logic_store_decode_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic instr_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [63:0] source_a_data = 64'h0;
    logic [63:0] source_b_data = 64'h0;
    logic user_or_super = 1'b0;
    logic sysctl_enabled = 1'b1;
    logic [4:0] flt = 5'h0;
    logic [4:0] sysctl_raddr, gpr_waddr, sysctl_waddr, exc_code;
    logic gpr_we, sysctl_we, store_req, exc_valid, product_undefined;
    logic [63:0] gpr_wdata, sysctl_wdata, store_addr, upper_product_reg, bottom_product_reg;
    logic [7:0] store_byte;
    logic [63:0] m_hi = 64'h0, m_lo = 64'h0;
    logic [31:0] seed = 32'hf1eb_f96c;
    logic [4:0] ec [5] = '{5'h02, 5'h03, 5'h01, 5'h07, 5'h05};
    logic [73:0] expq[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    // Data follows the read address, so a wrong address shows up
    wire logic [63:0] sysctl_rdata = {8{3'h5, sysctl_raddr}};

    always #5 ref_clk = ~ref_clk;

    hilo_cop_logic_store_decode hilo_cop_logic_store_decode_i (
        .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .source_a_data(source_a_data), .source_b_data(source_b_data),
        .user_or_super(user_or_super), .sysctl_enabled(sysctl_enabled),
        .sysctl_rdata(sysctl_rdata), .mem_tlb_refill(flt[0]), .mem_tlb_invalid(flt[1]),
        .mem_tlb_modified(flt[2]), .mem_bus_error(flt[3]), .mem_addr_error(flt[4]),
        .source_a_field(), .source_b_field(), .sysctl_raddr(sysctl_raddr),
        .gpr_we(gpr_we), .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata),
        .sysctl_we(sysctl_we), .sysctl_waddr(sysctl_waddr), .sysctl_wdata(sysctl_wdata),
        .store_req(store_req), .store_addr(store_addr), .store_byte(store_byte),
        .exc_valid(exc_valid), .exc_code(exc_code), .upper_product_reg(upper_product_reg),
        .bottom_product_reg(bottom_product_reg), .product_undefined(product_undefined));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [63:0] rnd64();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return {seed, seed ^ 32'h5a5a_5a5a};
    endfunction : rnd64

    function automatic logic [63:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction : sx

    task automatic check(input logic [73:0] seen, input logic [73:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic take(input logic [73:0] v);
        if (expq.size() == 0) check(v, ~v);
        else check(v, expq.pop_front());
    endtask : take

    // Inputs are scrambled right after the sampling edge, before the take
    task automatic issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
                         input logic [4:0] f);
        instr <= w;
        source_a_data <= a;
        source_b_data <= b;
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        instr <= ~w;
        source_a_data <= ~a;
        source_b_data <= ~b;
        flt <= f;
        @(posedge ref_clk);
        flt <= 5'h0;
        repeat (3) @(posedge ref_clk);
        check(74'(upper_product_reg), 74'(m_hi));
        check(74'(bottom_product_reg), 74'(m_lo));
    endtask : issue

    // Two fillers keep the read spacing
    task automatic rd_back();
        expq.push_back({10'h003, m_hi});
        issue({16'h0, 5'h03, 5'h0, isa_decode_pkg::FN_RD_UP}, 64'h0, 64'h0, 5'h0);
        expq.push_back({10'h005, m_lo});
        issue({16'h0, 5'h05, 5'h0, isa_decode_pkg::FN_RD_BOT}, 64'h0, 64'h0, 5'h0);
        repeat (2) begin
            expq.push_back(74'h0);
            issue({26'h0, isa_decode_pkg::FN_OR}, 64'h0, 64'h0, 5'h0);
        end
    endtask : rd_back

    task automatic put(input logic [63:0] h, input logic [63:0] l);
        m_hi = h;
        issue({6'h0, 5'h01, 15'h0, isa_decode_pkg::FN_WR_UP}, h, 64'h0, 5'h0);
        m_lo = l;
        issue({6'h0, 5'h01, 15'h0, isa_decode_pkg::FN_WR_BOT}, l, 64'h0, 5'h0);
    endtask : put

    task automatic acc(input logic us, input logic up, input logic [63:0] a,
                       input logic [63:0] b);
        logic signed [65:0] p;
        logic signed [65:0] s;
        logic [63:0] t;
        if (us) p = {34'h0, a[31:0]} * {34'h0, b[31:0]};
        else p = $signed({{34{a[31]}}, a[31:0]}) * $signed({{34{b[31]}}, b[31:0]});
        s = p + $signed({us ? 2'h0 : {2{m_hi[31]}}, m_hi[31:0], m_lo[31:0]});
        t = s[63:0];
        if (us && s[64]) t = isa_decode_pkg::SAT_UMAX;
        if (!us && s > 66'sh7fff_ffff) t = isa_decode_pkg::SAT_POS;
        if (!us && s < -66'sh8000_0000) t = isa_decode_pkg::SAT_NEG;
        m_lo = sx(t[63:32]);
        m_hi = sx(t[31:0]);
        expq.push_back({10'h004, up ? m_hi : m_lo});
        issue({isa_decode_pkg::OP_MACC, 10'h022, 5'h04, 1'b1, up, 2'h0, us,
               isa_decode_pkg::FN_MACC}, a, b, 5'h0);
    endtask : acc

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // Checking and stimulus
    // ----------------------------------------
    always @(posedge ref_clk) begin
        #1;
        if (gpr_we === 1'b1) take({5'h0, gpr_waddr, gpr_wdata});
        if (sysctl_we === 1'b1) take({5'h08, sysctl_waddr, sysctl_wdata});
        if (store_req === 1'b1) take({2'h2, store_byte, store_addr});
        if (exc_valid === 1'b1) take({5'h18, exc_code, 64'h0});
    end

    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        logic [63:0] a, b, r;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            a = rnd64();
            b = rnd64();
            r = rnd64();
            expq.push_back({5'h0, r[15:11], a | b});
            issue({6'h00, r[25:11], 5'h00, isa_decode_pkg::FN_OR}, a, b, 5'h0);
            expq.push_back({5'h0, r[15:11], ~(a | b)});
            issue({6'h00, r[25:11], 5'h00, isa_decode_pkg::FN_NOR}, a, b, 5'h0);
            expq.push_back({5'h0, r[20:16], a | {48'h0, r[15:0]}});
            issue({isa_decode_pkg::OP_ORI, r[25:0]}, a, b, 5'h0);
        end
        $display("logic tests done");
        m_lo = sx(32'hffff_ffeb);
        m_hi = '1;
        issue({16'h0022, 10'h0, isa_decode_pkg::FN_MUL_S}, 64'hffff_ffff_ffff_fffd, 64'h7, 5'h0);
        rd_back();
        m_lo = sx(32'hffff_fffe);
        m_hi = 64'h1;
        issue({16'h0022, 10'h0, isa_decode_pkg::FN_MUL_U}, '1, 64'h2, 5'h0);
        rd_back();
        m_lo = 64'h15;
        m_hi = 64'h0;
        issue({16'h0022, 10'h0, isa_decode_pkg::FN_MUL_S}, 64'h3, 64'h7, 5'h0);
        m_hi = isa_decode_pkg::UNDEF_VALUE;
        issue({6'h0, 5'h01, 15'h0, isa_decode_pkg::FN_WR_UP}, rnd64(), 64'h0, 5'h0);
        check(74'(product_undefined), 74'h1);
        $display("product tests done");
        put(64'h0, 64'h0);
        acc(1'b0, 1'b0, 64'h7fff_ffff, 64'h7fff_ffff);
        put(64'h0, 64'h0);
        acc(1'b0, 1'b1, 64'hffff_ffff_8000_0000, 64'h7fff_ffff);
        put(64'h0, 64'h5);
        acc(1'b1, 1'b0, 64'hffff_ffff, 64'h10);
        put(64'hffff_ffff, 64'hffff_ffff);
        acc(1'b1, 1'b1, 64'hffff_ffff, 64'hffff_ffff);
        $display("accumulate tests done");
        for (int m = 0; m < 4; m++) begin
            user_or_super <= m[0];
            sysctl_enabled <= m[1];
            b = rnd64();
            if (m == 1) expq.push_back({5'h18, isa_decode_pkg::ECODE_CPU, 64'h0});
            else expq.push_back({10'h007, {8{3'h5, 5'h0c}}});
            issue({isa_decode_pkg::OP_COP0, isa_decode_pkg::CP_READ, 10'h0ec, 11'h0}, a, b, 5'h0);
            if (m == 1) expq.push_back({5'h18, isa_decode_pkg::ECODE_CPU, 64'h0});
            else expq.push_back({10'h10c, b});
            issue({isa_decode_pkg::OP_COP0, isa_decode_pkg::CP_WRITE, 10'h0ec, 11'h0}, a, b, 5'h0);
        end
        $display("coprocessor tests done");
        rd_back();
        for (int i = 0; i < 6; i++) begin
            a = rnd64();
            b = rnd64();
            r = rnd64();
            expq.push_back({2'h2, b[7:0], a + {{48{r[15]}}, r[15:0]}});
            if (i > 0) expq.push_back({5'h18, ec[i - 1], 64'h0});
            issue({isa_decode_pkg::OP_SB, r[25:0]}, a, b, i == 0 ? 5'h0 : 5'(1 << (i - 1)));
        end
        $display("store tests done");
        check(74'(expq.size()), 74'h0);
        print_verdict();
    end
endmodule : hilo_cop_logic_store_decode_tb

// *** design/clamp_unit.sv ***
// Saturating 64-bit accumulate used by the clamped multiply-accumulate forms
`timescale 1ns/100ps
module clamp_unit (
    input wire logic [63:0] product,
    input wire logic [63:0] acc,
    input wire logic unsigned_flag,
    output logic [63:0] sum
);
    logic [64:0] raw;
    always_comb begin
        raw = {1'b0, product} + {1'b0, acc};
        if (unsigned_flag) begin
            sum = raw[64] ? isa_decode_pkg::SAT_UMAX : raw[63:0];
        end else if ($signed(raw[63:0]) > $signed(isa_decode_pkg::SAT_POS)) begin
            sum = isa_decode_pkg::SAT_POS; // RL23
        end else if ($signed(raw[63:0]) < $signed(isa_decode_pkg::SAT_NEG)) begin
            sum = isa_decode_pkg::SAT_NEG; // RL23
        end else begin
            sum = raw[63:0];
        end
    end
endmodule : clamp_unit

// *** design/hilo_cop_logic_store_decode.sv ***
// Decode and execute of product-register, coprocessor, logic and byte-store ops
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module hilo_cop_logic_store_decode (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] source_a_data,
    input wire logic [63:0] source_b_data,
    input wire logic user_or_super,
    input wire logic sysctl_enabled,
    input wire logic [63:0] sysctl_rdata,
    input wire logic mem_tlb_refill,
    input wire logic mem_tlb_invalid,
    input wire logic mem_tlb_modified,
    input wire logic mem_bus_error,
    input wire logic mem_addr_error,
    output logic [4:0] source_a_field,
    output logic [4:0] source_b_field,
    output logic [4:0] sysctl_raddr,
    output logic gpr_we,
    output logic [4:0] gpr_waddr,
    output logic [63:0] gpr_wdata,
    output logic sysctl_we,
    output logic [4:0] sysctl_waddr,
    output logic [63:0] sysctl_wdata,
    output logic store_req,
    output logic [63:0] store_addr,
    output logic [7:0] store_byte,
    output logic exc_valid,
    output logic [4:0] exc_code,
    output logic [63:0] upper_product_reg,
    output logic [63:0] bottom_product_reg,
    output logic product_undefined
);
    // --------------------------------------------------------------
    // Reset synchroniser
    // --------------------------------------------------------------
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // --------------------------------------------------------------
    // Field decode
    // --------------------------------------------------------------
    logic [5:0] opcode;
    logic [5:0] funct;
    logic [4:0] dest_field;
    logic [4:0] cop_sub;
    logic [15:0] imm;
    assign opcode = instr[31:26];
    assign funct = instr[5:0];
    assign source_a_field = instr[25:21];
    assign source_b_field = instr[20:16];
    assign dest_field = instr[15:11];
    assign cop_sub = instr[25:21];
    assign imm = instr[15:0];
    assign sysctl_raddr = instr[15:11];

    logic is_special;
    logic is_macc;
    logic is_cop;
    logic cop_read;
    logic cop_write;
    logic cop_trap;
    logic upper_select;
    logic unsigned_flag;
    assign is_special = instr_valid && opcode == isa_decode_pkg::OP_SPECIAL;
    assign is_macc = instr_valid && opcode == isa_decode_pkg::OP_MACC
        && funct == isa_decode_pkg::FN_MACC && instr[isa_decode_pkg::BIT_SAT];
    assign is_cop = instr_valid && opcode == isa_decode_pkg::OP_COP0 && instr[10:0] == 11'h000;
    assign cop_read = is_cop && cop_sub == isa_decode_pkg::CP_READ;
    assign cop_write = is_cop && cop_sub == isa_decode_pkg::CP_WRITE;
    assign cop_trap = (cop_read || cop_write) && user_or_super && !sysctl_enabled; // RL6
    assign upper_select = instr[isa_decode_pkg::BIT_UPPER];
    assign unsigned_flag = instr[isa_decode_pkg::BIT_UNS];

    // --------------------------------------------------------------
    // Multiply and clamped accumulate datapath
    // --------------------------------------------------------------
    logic [63:0] ext_a;
    logic [63:0] ext_b;
    logic [63:0] product;
    logic [63:0] sat_sum;
    logic [63:0] acc_sum;
    logic [63:0] next_bottom;
    logic [63:0] next_upper;
    always_comb begin
        if (unsigned_flag || funct == isa_decode_pkg::FN_MUL_U) begin
            ext_a = {32'h0, source_a_data[31:0]}; // RL2
            ext_b = {32'h0, source_b_data[31:0]};
        end else begin
            ext_a = {{32{source_a_data[31]}}, source_a_data[31:0]}; // RL1
            ext_b = {{32{source_b_data[31]}}, source_b_data[31:0]};
        end
        product = ext_a * ext_b; // RL16 RL17
    end
    assign acc_sum = {upper_product_reg[31:0], bottom_product_reg[31:0]};
    clamp_unit u_clamp (
        .product(product),
        .acc(acc_sum),
        .unsigned_flag(unsigned_flag),
        .sum(sat_sum)
    );
    // Bottom takes the high half of the sum and upper the low half
    assign next_bottom = {{32{sat_sum[63]}}, sat_sum[63:32]}; // RL4
    assign next_upper = {{32{sat_sum[31]}}, sat_sum[31:0]}; // RL4

    // --------------------------------------------------------------
    // Product registers
    // --------------------------------------------------------------
    logic mul_pending;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_product_reg <= isa_decode_pkg::PRODUCT_RESET;
            bottom_product_reg <= isa_decode_pkg::PRODUCT_RESET;
            mul_pending <= 1'b0;
            product_undefined <= 1'b0;
        end else if (is_macc) begin
            bottom_product_reg <= next_bottom; // RL1 RL2
            upper_product_reg <= next_upper; // RL3 RL4
            mul_pending <= 1'b0;
            product_undefined <= 1'b0;
        end else if (is_special) begin
            case (funct)
                isa_decode_pkg::FN_MUL_S, isa_decode_pkg::FN_MUL_U: begin
                    bottom_product_reg <= {{32{product[31]}}, product[31:0]}; // RL16 RL17
                    upper_product_reg <= {{32{product[63]}}, product[63:32]}; // RL16 RL17
                    mul_pending <= 1'b1;
                    product_undefined <= 1'b0;
                end
                isa_decode_pkg::FN_WR_UP: begin
                    // A move right after a multiply leaves the register with no defined value
                    upper_product_reg <= mul_pending ? isa_decode_pkg::UNDEF_VALUE
                        : source_a_data; // RL13 RL14
                    product_undefined <= mul_pending; // RL14
                    mul_pending <= 1'b0;
                end
                isa_decode_pkg::FN_WR_BOT: begin
                    bottom_product_reg <= mul_pending ? isa_decode_pkg::UNDEF_VALUE
                        : source_a_data; // RL15
                    product_undefined <= mul_pending; // RL15
                    mul_pending <= 1'b0;
                end
                isa_decode_pkg::FN_RD_UP, isa_decode_pkg::FN_RD_BOT: begin
                    mul_pending <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // General register write-back
    // --------------------------------------------------------------
    logic next_we;
    logic [4:0] next_waddr;
    logic [63:0] next_wdata;
    always_comb begin
        next_we = 1'b0;
        next_waddr = dest_field;
        next_wdata = 64'h0;
        if (is_macc) begin
            next_we = 1'b1;
            next_wdata = upper_select ? next_upper : next_bottom; // RL1 RL2 RL3 RL4
        end else if (cop_read && !cop_trap) begin
            next_we = 1'b1;
            next_waddr = source_b_field;
            next_wdata = sysctl_rdata; // RL5
        end else if (instr_valid && opcode == isa_decode_pkg::OP_ORI) begin
            next_we = 1'b1;
            next_waddr = source_b_field;
            next_wdata = {source_a_data[63:16], source_a_data[15:0] | imm}; // RL21
        end else if (is_special) begin
            case (funct)
                isa_decode_pkg::FN_RD_UP: begin
                    next_we = 1'b1;
                    next_wdata = upper_product_reg; // RL9
                end
                isa_decode_pkg::FN_RD_BOT: begin
                    next_we = 1'b1;
                    next_wdata = bottom_product_reg; // RL11
                end
                isa_decode_pkg::FN_OR: begin
                    next_we = 1'b1;
                    next_wdata = source_a_data | source_b_data; // RL20
                end
                isa_decode_pkg::FN_NOR: begin
                    next_we = 1'b1;
                    next_wdata = ~(source_a_data | source_b_data); // RL19
                end
                default: begin
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpr_we <= 1'b0;
            gpr_waddr <= 5'h00;
            gpr_wdata <= 64'h0;
        end else begin
            gpr_we <= next_we;
            gpr_waddr <= next_waddr;
            gpr_wdata <= next_wdata;
        end
    end

    // --------------------------------------------------------------
    // Coprocessor write, two stages
    // --------------------------------------------------------------
    logic cw_stage;
    logic [4:0] cw_addr;
    logic [63:0] cw_data;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cw_stage <= 1'b0;
            cw_addr <= 5'h00;
            cw_data <= 64'h0;
            sysctl_we <= 1'b0;
            sysctl_waddr <= 5'h00;
            sysctl_wdata <= 64'h0;
        end else begin
            cw_stage <= cop_write && !cop_trap;
            cw_addr <= dest_field;
            cw_data <= source_b_data; // RL7
            sysctl_we <= cw_stage; // RL7
            sysctl_waddr <= cw_addr;
            sysctl_wdata <= cw_data;
        end
    end

    // --------------------------------------------------------------
    // Byte store and exceptions
    // --------------------------------------------------------------
    logic is_sb;
    logic mem_fault;
    logic store_out;
    assign is_sb = instr_valid && opcode == isa_decode_pkg::OP_SB;
    assign mem_fault = mem_tlb_refill || mem_tlb_invalid || mem_tlb_modified
        || mem_bus_error || mem_addr_error;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            store_req <= 1'b0;
            store_addr <= 64'h0;
            store_byte <= 8'h00;
            store_out <= 1'b0;
        end else begin
            store_req <= is_sb;
            store_out <= is_sb;
            if (is_sb) begin
                store_addr <= source_a_data + {{48{imm[15]}}, imm}; // RL22
                store_byte <= source_b_data[7:0]; // RL22
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_valid <= 1'b0;
            exc_code <= 5'h00;
        end else if (cop_trap) begin
            exc_valid <= 1'b1;
            exc_code <= isa_decode_pkg::ECODE_CPU; // RL6
        end else if (store_out && mem_fault) begin
            exc_valid <= 1'b1;
            exc_code <= mem_tlb_refill ? 5'h02 : mem_tlb_invalid ? 5'h03
                : mem_tlb_modified ? 5'h01 : mem_bus_error ? 5'h07 : 5'h05; // RL24
        end else begin
            exc_valid <= 1'b0;
        end
    end
endmodule : hilo_cop_logic_store_decode

// *** pkg/isa_decode_pkg.sv ***
// Constants for the multiply, coprocessor, logic and byte-store decoder
// Contract
// RL1: Signed clamped accumulate, bottom dest: sign-extend, add, clamp, bottom to rd.
// RL2: Unsigned clamped accumulate, bottom dest: zero-extend, clamp, bottom to rd.
// RL3: Signed clamped accumulate, upper dest: as RL1 but upper to rd.
// RL4: Unsigned upper variant: bottom gets sum 63..32, upper 31..0, upper to rd.
// RL5: Coprocessor read copies selected control register into rt.
// RL6: Coprocessor moves trap unusable in user/supervisor mode unless enabled.
// RL7: Coprocessor write takes rt at T, writes register at T+1.
// RL8: Software avoids memory/translation ops right beside a coprocessor write.
// RL9: Upper read copies upper product register into rd.
// RL10: Two instructions after upper read must not modify upper register.
// RL11: Bottom read copies bottom product register into rd.
// RL12: Two instructions after bottom read must not modify bottom register.
// RL13: Upper write loads upper register from rs.
// RL14: Upper write right after multiply marks upper register undefined.
// RL15: Bottom write loads bottom from rs; undefined right after multiply.
// RL16: Signed multiply, no overflow trap, low word bottom, high word upper.
// RL17: Unsigned multiply, no overflow trap, split result bottom and upper.
// RL18: Software keeps two instructions between result reads and a multiply.
// RL19: NOR writes inverted OR of sources into rd.
// RL20: OR writes OR of sources into rd.
// RL21: OR-immediate zero-extends immediate, ORs low half, keeps upper bits.
// RL22: Byte store adds sign-extended offset to base, stores low byte.
// RL23: Signed clamp: overflow to max positive, underflow to min negative.
// RL24: Byte store reports translation, bus and address errors as exceptions; a coprocessor trap in the fault's cycle wins and the fault is dropped.
package isa_decode_pkg;
    // --------------------------------------------------------------
    // Opcode and function codes
    // --------------------------------------------------------------
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_COP0 = 6'h10;
    localparam logic [5:0] OP_ORI = 6'h0d;
    localparam logic [5:0] OP_SB = 6'h28;
    localparam logic [5:0] OP_MACC = 6'h1c;
    localparam logic [5:0] FN_MACC = 6'h28;
    localparam logic [4:0] CP_READ = 5'h00;
    localparam logic [4:0] CP_WRITE = 5'h04;
    localparam logic [5:0] FN_RD_UP = 6'h10;
    localparam logic [5:0] FN_WR_UP = 6'h11;
    localparam logic [5:0] FN_RD_BOT = 6'h12;
    localparam logic [5:0] FN_WR_BOT = 6'h13;
    localparam logic [5:0] FN_MUL_S = 6'h18;
    localparam logic [5:0] FN_MUL_U = 6'h19;
    localparam logic [5:0] FN_OR = 6'h25;
    localparam logic [5:0] FN_NOR = 6'h27;
    // --------------------------------------------------------------
    // Accumulate control bit positions in the shamt field
    // --------------------------------------------------------------
    localparam int BIT_SAT = 10;
    localparam int BIT_UPPER = 9;
    localparam int BIT_UNS = 6;
    // --------------------------------------------------------------
    // Clamp limits and reset values
    // --------------------------------------------------------------
    localparam logic [63:0] SAT_POS = 64'h0000_0000_7fff_ffff;
    localparam logic [63:0] SAT_NEG = 64'hffff_ffff_8000_0000;
    localparam logic [63:0] SAT_UMAX = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] PRODUCT_RESET = 64'h0;
    // Value shown for a result register whose content is undefined
    localparam logic [63:0] UNDEF_VALUE = 64'h0;
    localparam logic [4:0] ECODE_CPU = 5'h0b;
    localparam logic [4:0] ECODE_RI = 5'h0a;
endpackage : isa_decode_pkg
